// [common/fsad_pkg.sv]
// Purpose: constants and carrier types for the frame slot address decoder
// Assumes: one 50 MHz core clock, strap pins asynchronous to it
// Notes:   switch is four bits wide so out-of-range readings can be seen
package fsad_pkg;

	// strap and channel geometry
	localparam int          SW_W          = 4;
	localparam logic [3:0]  SW_MAX        = 4'h7;
	localparam int          SW_ROLE_BIT   = 2;
	localparam int          CHAN_W        = 12;
	localparam int          BLK_SHIFT     = 9;
	localparam logic [11:0] CHAN_BLOCK    = 12'h200;
	localparam logic [11:0] CHAN_ONE      = 12'h001;
	localparam int          AUD_CH_W      = 11;
	localparam int          AUD_DEPTH     = 2048;
	localparam int          MAX_BLK       = 4;

	// factory defaults: 192.168.1.201 and 255.255.0.0
	localparam logic [31:0] DEF_BASE_ADDR = 32'hC0A801C9;
	localparam logic [31:0] DEF_NET_MASK  = 32'hFFFF0000;

	// cycles the second synchroniser stage needs before sampling
	localparam logic [1:0]  SETTLE_CYC    = 2'h3;

	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_SAMPLE,
		ST_RUN
	} fsad_state_t;

	// decoded identity of this controller
	typedef struct packed {
		logic        valid;
		logic        err;
		logic        redundant;
		logic [11:0] chan_first;
		logic [11:0] chan_last;
		logic [31:0] op_addr;
		logic [31:0] net_mask;
	} fsad_dec_t;

	// hardware configuration: audio blocks and their channel ranges
	typedef struct packed {
		logic [2:0]        blk_count;
		logic [3:0][3:0]   blk_type;
		logic [3:0][11:0]  blk_first;
	} fsad_hw_cfg_t;

	// per-channel audio settings
	typedef struct packed {
		logic [5:0] gain;
		logic [3:0] balance;
		logic       invert;
		logic [1:0] remedy;
	} fsad_aud_t;

	localparam fsad_hw_cfg_t HW_CFG_RST = '0;
	localparam fsad_dec_t    DEC_RST    = '{valid: 1'b0, err: 1'b0,
		redundant: 1'b0, chan_first: 12'h000, chan_last: 12'h000,
		op_addr: 32'h00000000, net_mask: DEF_NET_MASK};

endpackage

// [core/fsad_decoder.sv]
// Purpose: derive role, channel block and network address of a frame
//          controller from its frame switch and slot, and hold the
//          downloaded hardware and per-channel audio configuration
// Assumes: straps are static pins; host enforces address octet limits
// Notes:   address is recomputed after every base address save with switch 0 to 7
//
// Operation
// - Switch readings 0 to 3 mark the frame primary, 4 to 7 redundant.
// - Switch modulo four picks the 512-channel block, 1-512 to 1537-2048.
// - Operating address adds twice the switch plus slot to octet four.
// - Base address resets to 192.168.1.201 and subnet mask is 255.255.0.0.
// - Hardware configuration changes only on an explicit download strobe.
// - A configuration fetch returns the currently applied configuration.
// - Host, system and up to 16 frame controllers share one Ethernet.
// - Hardware configuration holds block count, types and channel ranges.
// - Per-channel gain, balance, inversion, remedy sit in their own store.
// - Saving a new base address stores it and restarts the decode.
`timescale 1ns/1ps

module fsad_decoder
	import fsad_pkg::*;
(
	// clock and reset
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST_B,
	// straps from the mid-plane and slot
	input  wire logic [SW_W-1:0]       SWITCH_POS,
	input  wire logic                  SLOT_SEL,
	// base address save from host
	input  wire logic                  BASE_WR,
	input  wire logic [31:0]           BASE_ADDR_IN,
	// hardware configuration download and fetch
	input  wire logic                  DL_STB,
	input  wire fsad_hw_cfg_t          DL_CFG,
	input  wire logic                  CFG_RD_REQ,
	output logic                       CFG_RD_ACK,
	output fsad_hw_cfg_t               CFG_RD_DATA,
	// per-channel audio settings
	input  wire logic                  AUD_WR,
	input  wire logic                  AUD_RD,
	input  wire logic [AUD_CH_W-1:0]   AUD_CH,
	input  wire fsad_aud_t             AUD_WDATA,
	output logic                       AUD_RACK,
	output fsad_aud_t                  AUD_RDATA,
	// decoded identity
	output fsad_dec_t                  DECODE,
	output logic [31:0]                BASE_ADDR
);

	function automatic logic [11:0] block_first(input logic [SW_W-1:0] sw);
		block_first = CHAN_ONE + (12'(sw[1:0]) << BLK_SHIFT);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// strap synchronisers

	logic [SW_W-1:0] sw_s1;
	logic [SW_W-1:0] sw_s2;
	logic            slot_s1;
	logic            slot_s2;

	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			sw_s1   <= '0;
			sw_s2   <= '0;
			slot_s1 <= 1'b0;
			slot_s2 <= 1'b0;
		end
		else
		begin
			sw_s1   <= SWITCH_POS;
			sw_s2   <= sw_s1;
			slot_s1 <= SLOT_SEL;
			slot_s2 <= slot_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// base address store and decode sequence

	fsad_state_t     state;
	fsad_state_t     next_state;
	logic [1:0]      cnt;
	logic [1:0]      next_cnt;
	logic [31:0]     base;
	logic [31:0]     next_base;
	fsad_dec_t       dec;
	fsad_dec_t       next_dec;
	logic [SW_W-1:0] sw_cap;
	logic [SW_W-1:0] next_sw_cap;
	logic            slot_cap;
	logic            next_slot_cap;

	always_comb
	begin
		next_state    = state;
		next_cnt      = cnt;
		next_base     = base;
		next_dec      = dec;
		next_sw_cap   = sw_cap;
		next_slot_cap = slot_cap;
		case (state)
			ST_SETTLE:
			begin
				// let the strap value reach the second stage first
				next_cnt = cnt + 2'h1;
				if (cnt == SETTLE_CYC - 2'h1)
					next_state = ST_SAMPLE;
			end
			ST_SAMPLE:
			begin
				next_sw_cap   = sw_s2;
				next_slot_cap = slot_s2;
				next_state    = ST_RUN;
				if (sw_s2 > SW_MAX)
				begin
					next_dec.err   = 1'b1;
					next_dec.valid = 1'b0;
				end
				else
				begin
					next_dec.err        = 1'b0;
					next_dec.valid      = 1'b1;
					next_dec.redundant  = sw_s2[SW_ROLE_BIT];
					next_dec.chan_first = block_first(sw_s2);
					next_dec.chan_last  = block_first(sw_s2)
						+ CHAN_BLOCK - CHAN_ONE;
					// sixteen slots of offset, 0 to 15
					next_dec.op_addr    = {base[31:8], base[7:0]
						+ {4'h0, sw_s2[2:0], slot_s2}};
				end
			end
			ST_RUN:
			begin
			end
			default:
				next_state = ST_SETTLE;
		endcase
		next_dec.net_mask = DEF_NET_MASK;
		if (BASE_WR)
		begin
			// store first, then restart as a reboot would
			next_base      = BASE_ADDR_IN;
			next_state     = ST_SETTLE;
			next_cnt       = 2'h0;
			next_dec.valid = 1'b0;
			next_dec.err   = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state    <= ST_SETTLE;
			cnt      <= 2'h0;
			base     <= DEF_BASE_ADDR;
			dec      <= DEC_RST;
			sw_cap   <= '0;
			slot_cap <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			base     <= next_base;
			dec      <= next_dec;
			sw_cap   <= next_sw_cap;
			slot_cap <= next_slot_cap;
		end
	end

	assign DECODE    = dec;
	assign BASE_ADDR = base;

	////////////////////////////////////////////////////////////////////////
	// hardware configuration, staged at the host until downloaded

	fsad_hw_cfg_t hw_cfg;
	fsad_hw_cfg_t next_hw_cfg;
	fsad_hw_cfg_t rd_data;
	fsad_hw_cfg_t next_rd_data;
	logic         rd_ack;
	logic         next_rd_ack;

	always_comb
	begin
		next_hw_cfg  = hw_cfg;
		next_rd_data = rd_data;
		next_rd_ack  = CFG_RD_REQ;
		if (CFG_RD_REQ)
			next_rd_data = hw_cfg;
		if (DL_STB)
			next_hw_cfg = DL_CFG;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			hw_cfg  <= HW_CFG_RST;
			rd_data <= HW_CFG_RST;
			rd_ack  <= 1'b0;
		end
		else
		begin
			hw_cfg  <= next_hw_cfg;
			rd_data <= next_rd_data;
			rd_ack  <= next_rd_ack;
		end
	end

	assign CFG_RD_ACK  = rd_ack;
	assign CFG_RD_DATA = rd_data;

	////////////////////////////////////////////////////////////////////////
	// per-channel audio settings; kept apart from routing data

	fsad_aud_t aud_mem [AUD_DEPTH];
	fsad_aud_t aud_q;
	logic      aud_ack;
	logic      next_aud_ack;

	// memory has no reset: contents are undefined until written
	always_ff @(posedge CORE_CLK)
	begin
		if (AUD_WR)
			aud_mem[AUD_CH] <= AUD_WDATA;
		if (AUD_RD)
			aud_q <= aud_mem[AUD_CH];
	end

	always_comb
	begin
		next_aud_ack = AUD_RD;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B)
	begin
		if (!RST_B)
			aud_ack <= 1'b0;
		else
			aud_ack <= next_aud_ack;
	end

	assign AUD_RACK  = aud_ack;
	assign AUD_RDATA = aud_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	role_map_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		dec.valid |-> dec.redundant == (sw_cap > 4'h3))
		else $error("frame role does not follow switch");

	chan_block_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		dec.valid |-> (dec.chan_first == ({10'h000, sw_cap[1:0]} * 12'h200
			+ 12'h001)) && (dec.chan_last == dec.chan_first + 12'h1FF))
		else $error("channel block wrong for switch");

	op_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		dec.valid |-> dec.op_addr == {base[31:8], base[7:0]
			+ 8'(2 * sw_cap[2:0]) + {7'h00, slot_cap}})
		else $error("operating address offset wrong");

	net_defaults_a: assert property (@(posedge CORE_CLK)
		$rose(RST_B) |-> base == 32'hC0A801C9 && dec.net_mask == 32'hFFFF0000)
		else $error("factory network defaults missing");

	staged_cfg_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!DL_STB |=> $stable(hw_cfg))
		else $error("configuration changed without download");

	cfg_fetch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CFG_RD_REQ |=> CFG_RD_ACK && CFG_RD_DATA == $past(hw_cfg))
		else $error("configuration fetch answer wrong");

	cfg_apply_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		DL_STB |=> hw_cfg == $past(DL_CFG))
		else $error("download not applied");

	aud_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		AUD_RD |=> AUD_RACK ##1 !AUD_RACK || $past(AUD_RD))
		else $error("audio read not answered in one cycle");

	base_restart_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		BASE_WR |=> base == $past(BASE_ADDR_IN) && !dec.valid
			##[4:5] (dec.valid || dec.err || BASE_WR))
		else $error("base save did not restart decode");

	strap_error_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		state == ST_SAMPLE && !BASE_WR |=> dec.err == (sw_cap > 4'h7)
			&& dec.valid != dec.err)
		else $error("invalid switch not flagged");

endmodule // fsad_decoder

// [tb/fsad_host_model.sv]
// Purpose: host model that stages, downloads and fetches configuration
// Assumes: drives on the falling clock edge, one request at a time
// Notes:   edits stay local until download is called
`timescale 1ns/1ps

module fsad_host_model
	import fsad_pkg::*;
(
	// clock
	input  wire logic         CORE_CLK,
	// base save and download
	output logic              BASE_WR,
	output logic [31:0]       BASE_ADDR_IN,
	output logic              DL_STB,
	output fsad_hw_cfg_t      DL_CFG,
	// configuration fetch
	output logic              CFG_RD_REQ,
	input  wire logic         CFG_RD_ACK,
	input  wire fsad_hw_cfg_t CFG_RD_DATA
);
	fsad_hw_cfg_t staged;

	initial
	begin
		BASE_WR      = 1'h0;
		BASE_ADDR_IN = 32'h0;
		DL_STB       = 1'h0;
		DL_CFG       = '0;
		CFG_RD_REQ   = 1'h0;
		staged       = '0;
	end

	////////////////////////////////////////////////////////////////////
	// octet four 0 and 255 never leave the host
	task automatic save_base(input logic [31:0] a);
		if (a[7:0] == 8'h00 || a[7:0] == 8'hFF)
			return;
		@(negedge CORE_CLK);
		BASE_WR      = 1'h1;
		BASE_ADDR_IN = a;
		@(negedge CORE_CLK);
		BASE_WR      = 1'h0;
		BASE_ADDR_IN = ~a;
	endtask

	// only the staged copy is sent, on an explicit command
	task automatic download();
		@(negedge CORE_CLK);
		DL_STB = 1'h1;
		DL_CFG = staged;
		@(negedge CORE_CLK);
		DL_STB = 1'h0;
		DL_CFG = ~staged;
	endtask

	// opening a view reads the applied configuration
	task automatic fetch(output fsad_hw_cfg_t d, output logic ack);
		@(negedge CORE_CLK);
		CFG_RD_REQ = 1'h1;
		@(negedge CORE_CLK);
		CFG_RD_REQ = 1'h0;
		ack        = CFG_RD_ACK;
		d          = CFG_RD_DATA;
	endtask

endmodule // fsad_host_model

// [tb/frame_slot_address_decoder_tb.sv]
// Purpose: self-checking bench for the frame slot address decoder
// Assumes: host model drives base save, download and fetch
// Notes:   decode is restarted by a base save rather than a reset
`timescale 1ns/1ps

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module frame_slot_address_decoder_tb
	import fsad_pkg::*;
;
	logic                CORE_CLK, RST_B, SLOT_SEL, BASE_WR, DL_STB;
	logic                CFG_RD_REQ, CFG_RD_ACK, AUD_WR, AUD_RD, AUD_RACK;
	logic [SW_W-1:0]     SWITCH_POS;
	logic [31:0]         BASE_ADDR_IN, BASE_ADDR;
	logic [AUD_CH_W-1:0] AUD_CH;
	fsad_hw_cfg_t        DL_CFG, CFG_RD_DATA;
	fsad_aud_t           AUD_WDATA, AUD_RDATA;
	fsad_dec_t           DECODE;
	int                  err_count = 0;
	int                  comparisons = 0;

	fsad_decoder DUT (.CORE_CLK, .RST_B, .SWITCH_POS, .SLOT_SEL, .BASE_WR,
		.BASE_ADDR_IN, .DL_STB, .DL_CFG, .CFG_RD_REQ, .CFG_RD_ACK,
		.CFG_RD_DATA, .AUD_WR, .AUD_RD, .AUD_CH, .AUD_WDATA, .AUD_RACK,
		.AUD_RDATA, .DECODE, .BASE_ADDR);

	fsad_host_model host (.CORE_CLK, .BASE_WR, .BASE_ADDR_IN, .DL_STB,
		.DL_CFG, .CFG_RD_REQ, .CFG_RD_ACK, .CFG_RD_DATA);

	////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// decode lands on the fourth edge after a restart
	task automatic settle();
		repeat (5) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
	endtask

	task automatic t_table();
		logic [31:0] b;
		b = 32'hC0A80565;
		for (int s = 0; s < 16; s++)
		begin
			@(negedge CORE_CLK);
			SWITCH_POS = 4'(s / 2);
			SLOT_SEL   = s[0];
			host.save_base(b);
			`CHK("base", b, BASE_ADDR)
			`CHK("restart", 1'h0, DECODE.valid)
			settle();
			`CHK("valid", 1'h1, DECODE.valid)
			`CHK("noerr", 1'h0, DECODE.err)
			`CHK("role", s >= 8, DECODE.redundant)
			`CHK("first", 12'(s / 2 % 4 * 512 + 1), DECODE.chan_first)
			`CHK("last", 12'(s / 2 % 4 * 512 + 512), DECODE.chan_last)
			`CHK("addr", {b[31:8], b[7:0] + 8'(s)}, DECODE.op_addr)
		end
	endtask

	// straps moving while running must not disturb the error result
	task automatic t_error();
		@(negedge CORE_CLK);
		SWITCH_POS = 4'h9;
		host.save_base(32'hC0A805FF);
		`CHK("refused", 32'hC0A80565, BASE_ADDR)
		host.save_base(32'hC0A80565);
		settle();
		SWITCH_POS = 4'h0;
		settle();
		`CHK("err", 1'h1, DECODE.err)
		`CHK("noval", 1'h0, DECODE.valid)
	endtask

	task automatic t_config();
		fsad_hw_cfg_t c, got;
		logic ack;
		c = {3'h4, 16'h4321, 48'h601401201001};
		host.fetch(got, ack);
		`CHK("ack", 1'h1, ack)
		`CHK("cfg0", 67'h0, got)
		host.staged = c;
		host.fetch(got, ack);
		`CHK("staged", 67'h0, got)
		host.download();
		host.fetch(got, ack);
		`CHK("cfg", c, got)
	endtask

	task automatic aud_op(input logic w, input logic [10:0] ch,
		input fsad_aud_t d);
		@(negedge CORE_CLK);
		AUD_WR    = w;
		AUD_RD    = !w;
		AUD_CH    = ch;
		AUD_WDATA = d;
		@(negedge CORE_CLK);
		AUD_WR    = 1'h0;
		AUD_RD    = 1'h0;
		AUD_WDATA = ~d;
	endtask

	task automatic t_audio();
		aud_op(1'h1, 11'h7FF, 13'h1A5B);
		aud_op(1'h1, 11'h000, 13'h0E4C);
		aud_op(1'h0, 11'h7FF, 13'h0000);
		`CHK("rack", 1'h1, AUD_RACK)
		`CHK("aud", 13'h1A5B, AUD_RDATA)
		aud_op(1'h0, 11'h000, 13'h0000);
		`CHK("aud0", 13'h0E4C, AUD_RDATA)
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		CORE_CLK = 1'h0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end

	// whole run is well under a thousand cycles
	initial
	begin
		#20000;
		err_count++;
		test_done();
	end

	initial
	begin
		RST_B      = 1'h0;
		SWITCH_POS = 4'h0;
		SLOT_SEL   = 1'h0;
		AUD_WR     = 1'h0;
		AUD_RD     = 1'h0;
		AUD_CH     = 11'h000;
		AUD_WDATA  = 13'h0000;
		repeat (4) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		RST_B = 1'h1;
		`CHK("defbase", 32'hC0A801C9, BASE_ADDR)
		settle();
		`CHK("mask", 32'hFFFF0000, DECODE.net_mask)
		`CHK("defaddr", 32'hC0A801C9, DECODE.op_addr)
		t_table();
		t_error();
		t_config();
		t_audio();
		test_done();
	end

endmodule // frame_slot_address_decoder_tb
